// file: verilog/ldm_pkg.sv
/*
  Package for the logger display and menu controller: page order, timing,
  character codes, status codes and threshold constants.
  Assumes a 40 MHz system clock and a one-second tick supplied by the system.
*/
package ldm_pkg;

  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned BOOT_WAIT_S     = 30;
  localparam int unsigned IDLE_OFF_S      = 240;
  localparam int unsigned PRESS_MAX_MS    = 500;
  localparam int unsigned PRESS_MAX_CYC   = CLK_HZ / 1000 * PRESS_MAX_MS;

  localparam int unsigned NUM_PAGES       = 20;
  localparam logic [4:0]  PAGE_FIRST      = 5'h00;
  localparam logic [4:0]  PAGE_LAST       = 5'h13;
  localparam logic [4:0]  PAGE_STATION    = 5'h00;
  localparam logic [4:0]  PAGE_RAIN1      = 5'h03;
  localparam logic [4:0]  PAGE_RAIN2      = 5'h04;
  localparam logic [4:0]  PAGE_TEMP       = 5'h05;
  localparam logic [4:0]  PAGE_HUMID      = 5'h06;
  localparam logic [4:0]  PAGE_SERIAL     = 5'h07;

  // Pages that are editable or offer more information, one bit per page.
  localparam logic [19:0] PAGE_EDIT_MASK  = 20'h0_FB9F;

  localparam logic [7:0]  CH_ASTERISK     = 8'h2A;
  localparam logic [7:0]  CH_SPACE        = 8'h20;
  localparam logic [7:0]  CH_M            = 8'h4D;
  localparam logic [7:0]  CH_PLUS         = 8'h2B;
  localparam logic [7:0]  CH_MINUS        = 8'h2D;
  localparam logic [7:0]  CH_ZERO         = 8'h30;
  localparam logic [7:0]  CH_ONE          = 8'h31;
  localparam logic [7:0]  CH_X            = 8'h58;
  localparam logic [7:0]  CH_QUEST        = 8'h3F;

  localparam logic [13:0] RAIN_MAX        = 14'h270F;
  localparam logic [13:0] BAT_OK_MIN      = 14'h0073;
  localparam logic [13:0] BAT_WARN_MIN    = 14'h006A;

  localparam logic [3:0]  BAUD_MAX_IDX    = 4'h9;
  localparam logic [4:0]  SAMP_MAX_IDX    = 5'h16;
  localparam logic [3:0]  STORE_MAX_IDX   = 4'hB;

  typedef enum logic [1:0] {
    LDM_BAT_OK,
    LDM_BAT_WARN,
    LDM_BAT_LOW
  } ldm_bat_type;

  typedef enum logic [1:0] {
    LDM_VAL_OK,
    LDM_VAL_INVALID,
    LDM_VAL_UNCONF
  } ldm_val_type;

  typedef enum logic [1:0] {
    LDM_OUT_NONE,
    LDM_OUT_CARD,
    LDM_OUT_SERIAL
  } ldm_route_type;

endpackage

// file: verilog/ldm_sec_timer.sv
/*
  Down counter of whole seconds, restarted by a load pulse.
  Assumes a one-cycle second tick synchronous to clk_i.
*/
`timescale 1ns/100ps
module ldm_sec_timer #(
  parameter int unsigned SECONDS = 30
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic load_i,
  input  wire logic run_i,
  input  wire logic tick_i,
  output logic      expired_o
);
  localparam int unsigned W = $clog2(SECONDS + 1);

  initial begin
    if (SECONDS < 1) $error("SECONDS must be at least one");
  end

  logic [W-1:0] count_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || load_i) begin
      count_q <= W'(SECONDS);
    end else if (run_i && tick_i && count_q != '0) begin
      count_q <= count_q - W'(1);
    end
  end

  assign expired_o = (count_q == '0);
endmodule

// file: verilog/ldm_chan_status.sv
/*
  Per-channel value state and status character for the four internal
  channels.  Assumes the flag inputs are steady levels from the front end.
*/
`timescale 1ns/100ps
module ldm_chan_status
  import ldm_pkg::*;
#(
  parameter int unsigned CHANNELS = 4
) (
  input  wire logic [CHANNELS-1:0]   configured_i,
  input  wire logic [CHANNELS-1:0]   present_i,
  input  wire logic [CHANNELS-1:0]   testable_i,
  input  wire logic [CHANNELS-1:0]   test_on_i,
  input  wire logic [CHANNELS-1:0]   range_ok_i,
  output logic [CHANNELS*8-1:0]      status_char_o,
  output logic [CHANNELS*2-1:0]      val_state_o
);
  for (genvar c = 0; c < CHANNELS; c++) begin : g_ch
    always_comb begin
      if (!configured_i[c]) begin
        status_char_o[c*8 +: 8] = CH_X;
      end else if (!testable_i[c]) begin
        status_char_o[c*8 +: 8] = CH_QUEST;
      end else if (!test_on_i[c]) begin
        status_char_o[c*8 +: 8] = CH_ZERO;
      end else if (present_i[c]) begin
        status_char_o[c*8 +: 8] = CH_PLUS;
      end else begin
        status_char_o[c*8 +: 8] = CH_MINUS;
      end
      if (!configured_i[c]) begin
        val_state_o[c*2 +: 2] = LDM_VAL_UNCONF;
      end else if (!present_i[c] || !range_ok_i[c]) begin
        val_state_o[c*2 +: 2] = LDM_VAL_INVALID;
      end else begin
        val_state_o[c*2 +: 2] = LDM_VAL_OK;
      end
    end
  end
endmodule

// file: verilog/ldm_top.sv
/*
  Display and menu controller of a battery data logger: boot wait, display
  on and idle switch-off, page navigation, markers and status fields, held
  over a classic Wishbone slave.
  Assumes a 40 MHz clock, a one-cycle tick each second, and button pulses
  that are already debounced and synchronous to clk_i.
*/
`timescale 1ns/100ps
module ldm_top
  import ldm_pkg::*;
#(
  parameter int unsigned BOOT_SECONDS = BOOT_WAIT_S,
  parameter int unsigned IDLE_SECONDS = IDLE_OFF_S,
  parameter int unsigned PRESS_CYCLES = PRESS_MAX_CYC
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         sec_tick_i,
  input  wire logic         btn_enter_i,
  input  wire logic         btn_up_i,
  input  wire logic         btn_down_i,
  input  wire logic         serial_activity_i,
  input  wire logic         card_present_i,
  input  wire logic         mains_present_i,
  input  wire logic         param_mem_ok_i,
  input  wire logic [13:0]  battery_dv_i,
  input  wire logic [3:0]   sensor_present_i,
  input  wire logic [3:0]   sensor_testable_i,
  input  wire logic [3:0]   sensor_range_ok_i,
  input  wire logic [13:0]  rain1_count_i,
  input  wire logic [13:0]  rain2_count_i,
  input  wire logic [15:0]  temp_i,
  input  wire logic [15:0]  humid_i,
  input  wire logic [31:0]  card_identity_record_i,
  input  wire logic         output_start_i,
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic [31:0]       wb_dat_o,
  output logic              wb_ack_o,
  output logic              firmware_run_o,
  output logic              display_on_o,
  output logic [4:0]        page_o,
  output logic [7:0]        line1_lead_o,
  output logic [7:0]        line2_lead_o,
  output logic              green_led_o,
  output logic [1:0]        route_o
);
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_NAME_LO = 8'h04;
  localparam logic [7:0] REG_NAME_HI = 8'h08;
  localparam logic [7:0] REG_SERIAL  = 8'h0C;
  localparam logic [7:0] REG_STATUS  = 8'h10;
  localparam logic [7:0] REG_RAIN    = 8'h14;
  localparam logic [7:0] REG_VALUES  = 8'h18;
  localparam logic [7:0] REG_CARD    = 8'h1C;
  localparam int unsigned PW = $clog2(PRESS_CYCLES + 1);

  initial begin
    if (BOOT_SECONDS < 1 || IDLE_SECONDS < 1 || PRESS_CYCLES < 1) begin
      $error("timing parameters must be at least one");
    end
  end

  // Control state written by software.
  logic [3:0]  sensor_cfg_q;
  logic [1:0]  test_flag_q;
  logic        maint_q;
  logic [1:0]  aux_func_q;
  logic [39:0] name_q;
  logic [3:0]  baud_idx_q;
  logic        frame_7e1_q;
  logic [4:0]  samp_idx_q;
  logic [3:0]  store_idx_q;

  logic        boot_done;
  logic        idle_expired;
  logic        disp_q;
  logic [4:0]  page_q;
  logic [PW-1:0] press_cnt_q;
  logic        enter_q;
  logic        wake;
  logic        aux_auto;
  logic        activity;

  logic [13:0] rain1_q;
  logic [13:0] rain2_q;
  logic [15:0] temp_q;
  logic [15:0] humid_q;
  logic [31:0] chars;
  logic [7:0]  vstate;
  logic [1:0]  bat_q;
  logic [1:0]  route_q;

  logic        wb_req;
  logic        wb_wr;

  ldm_sec_timer #(.SECONDS(BOOT_SECONDS)) u_boot (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (1'b0),
    .run_i     (1'b1),
    .tick_i    (sec_tick_i),
    .expired_o (boot_done)
  );

  assign activity = btn_enter_i || btn_up_i || btn_down_i ||
                    serial_activity_i;

  ldm_sec_timer #(.SECONDS(IDLE_SECONDS)) u_idle (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .load_i    (activity || !disp_q),
    .run_i     (1'b1),
    .tick_i    (sec_tick_i),
    .expired_o (idle_expired)
  );

  ldm_chan_status #(.CHANNELS(4)) u_chan (
    .configured_i  (sensor_cfg_q),
    .present_i     (sensor_present_i),
    .testable_i    (sensor_testable_i),
    .test_on_i     ({2'b11, test_flag_q}),
    .range_ok_i    (sensor_range_ok_i),
    .status_char_o (chars),
    .val_state_o   (vstate)
  );

  // The enter press only wakes the display when released within the limit.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enter_q     <= 1'b0;
      press_cnt_q <= '0;
    end else begin
      enter_q <= btn_enter_i;
      if (btn_enter_i && press_cnt_q != PW'(PRESS_CYCLES)) begin
        press_cnt_q <= press_cnt_q + PW'(1);
      end else if (!btn_enter_i) begin
        press_cnt_q <= '0;
      end
    end
  end

  assign wake = enter_q && !btn_enter_i &&
                press_cnt_q < PW'(PRESS_CYCLES);
  assign aux_auto = (aux_func_q != 2'b00);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      disp_q <= 1'b0;
    end else if (!disp_q) begin
      disp_q <= wake && boot_done;
    end else if (idle_expired && !aux_auto) begin
      disp_q <= 1'b0;
    end
  end

  // Page navigation with wrap at both ends.
  always_ff @(posedge clk_i) begin
    if (rst_i || !disp_q) begin
      page_q <= PAGE_STATION;
    end else if (btn_down_i && !btn_up_i) begin
      page_q <= (page_q == PAGE_LAST) ? PAGE_FIRST
                                      : page_q + 5'h01;
    end else if (btn_up_i && !btn_down_i) begin
      page_q <= (page_q == PAGE_FIRST) ? PAGE_LAST
                                       : page_q - 5'h01;
    end
  end

  // Measured values refreshed once per second.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rain1_q <= '0;
      rain2_q <= '0;
      temp_q  <= '0;
      humid_q <= '0;
      bat_q   <= LDM_BAT_OK;
    end else if (sec_tick_i) begin
      rain1_q <= (rain1_count_i > RAIN_MAX) ? RAIN_MAX
                                            : rain1_count_i;
      rain2_q <= (rain2_count_i > RAIN_MAX) ? RAIN_MAX
                                            : rain2_count_i;
      temp_q  <= temp_i;
      humid_q <= humid_i;
      if (battery_dv_i > BAT_OK_MIN) begin
        bat_q <= LDM_BAT_OK;
      end else if (battery_dv_i >= BAT_WARN_MIN) begin
        bat_q <= LDM_BAT_WARN;
      end else begin
        bat_q <= LDM_BAT_LOW;
      end
    end
  end

  // Output routing chosen when data output starts.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      route_q <= LDM_OUT_NONE;
    end else if (output_start_i) begin
      route_q <= card_present_i ? LDM_OUT_CARD
                                : LDM_OUT_SERIAL;
    end
  end

  always_comb begin
    line1_lead_o = PAGE_EDIT_MASK[page_q] ? CH_ASTERISK : CH_SPACE;
    if (maint_q && page_q >= PAGE_RAIN1 && page_q <= PAGE_SERIAL) begin
      line2_lead_o = CH_M;
    end else begin
      line2_lead_o = CH_SPACE;
    end
  end

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i;

  // Software-written control; writes outside the legal ranges are ignored.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sensor_cfg_q <= 4'hF;
      test_flag_q  <= 2'b00;
      maint_q      <= 1'b0;
      aux_func_q   <= 2'b00;
      name_q       <= '0;
      baud_idx_q   <= 4'h5;
      frame_7e1_q  <= 1'b0;
      samp_idx_q   <= '0;
      store_idx_q  <= '0;
    end else begin
      if (!disp_q) begin
        maint_q <= 1'b0;
      end
      if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        sensor_cfg_q <= wb_dat_i[3:0];
        test_flag_q  <= test_flag_q ^ wb_dat_i[5:4];
        maint_q      <= wb_dat_i[6];
      end
      if (wb_wr && wb_adr_i == REG_CTRL && wb_sel_i[1]) begin
        aux_func_q <= wb_dat_i[9:8];
      end
      if (wb_wr && wb_adr_i == REG_NAME_LO && wb_sel_i == 4'hF) begin
        name_q[31:0] <= wb_dat_i;
      end
      if (wb_wr && wb_adr_i == REG_NAME_HI && wb_sel_i[0]) begin
        name_q[39:32] <= wb_dat_i[7:0];
      end
      if (wb_wr && wb_adr_i == REG_SERIAL && wb_sel_i[0]) begin
        if (wb_dat_i[3:0] <= BAUD_MAX_IDX) begin
          baud_idx_q <= wb_dat_i[3:0];
        end
        frame_7e1_q <= wb_dat_i[4];
      end
      if (wb_wr && wb_adr_i == REG_SERIAL && wb_sel_i[1]) begin
        if (wb_dat_i[12:8] <= SAMP_MAX_IDX) begin
          samp_idx_q <= wb_dat_i[12:8];
        end
      end
      if (wb_wr && wb_adr_i == REG_SERIAL && wb_sel_i[2]) begin
        if (wb_dat_i[19:16] <= STORE_MAX_IDX) begin
          store_idx_q <= wb_dat_i[19:16];
        end
      end
    end
  end

  // Read data and ack, one cycle after the request.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          REG_CTRL:    wb_dat_o <= {22'h0, aux_func_q, 1'b0, maint_q,
                                    test_flag_q, sensor_cfg_q};
          REG_NAME_LO: wb_dat_o <= name_q[31:0];
          REG_NAME_HI: wb_dat_o <= {24'h0, name_q[39:32]};
          REG_SERIAL:  wb_dat_o <= {12'h0, store_idx_q, 3'h0, samp_idx_q,
                                    3'h0, frame_7e1_q, baud_idx_q};
          // Command port function is fixed, bit 31 reads one always.
          REG_STATUS:  wb_dat_o <= {1'b1, 9'h0, route_q, bat_q,
                                    param_mem_ok_i, mains_present_i,
                                    card_present_i, disp_q,
                                    boot_done, page_q, vstate};
          REG_RAIN:    wb_dat_o <= {2'h0, rain2_q, 2'h0, rain1_q};
          REG_VALUES:  wb_dat_o <= {humid_q, temp_q};
          REG_CARD:    wb_dat_o <= card_present_i ? card_identity_record_i
                                                  : chars;
          default:     wb_dat_o <= '0;
        endcase
      end
    end
  end

  assign firmware_run_o = boot_done;
  assign display_on_o   = disp_q;
  assign page_o         = page_q;
  assign green_led_o    = mains_present_i;
  assign route_o        = route_q;
endmodule

// file: testbench/ldm_top_chk.sv
/*
  Checker for ldm_top: bus answer timing, line-one page marker, navigation, boot
  order and output routing.
  Assumes it is bound to ldm_top and sees only that module's ports.
*/
`timescale 1ns/100ps
module ldm_top_chk
  import ldm_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       sec_tick_i,
  input wire logic       btn_enter_i,
  input wire logic       btn_up_i,
  input wire logic       btn_down_i,
  input wire logic       card_present_i,
  input wire logic       mains_present_i,
  input wire logic       output_start_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       firmware_run_o,
  input wire logic       display_on_o,
  input wire logic [4:0] page_o,
  input wire logic [7:0] line1_lead_o,
  input wire logic       green_led_o,
  input wire logic [1:0] route_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_nav;
    display_on_o && !btn_enter_i && !sec_tick_i && (btn_up_i ^ btn_down_i);
  endsequence

  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_wake_station: assert property ($rose(display_on_o) |-> page_o == PAGE_STATION)
    else $error("display woke on wrong page");
  a_edit_marker: assert property (line1_lead_o == (PAGE_EDIT_MASK[page_o] ? CH_ASTERISK : CH_SPACE))
    else $error("line one marker wrong");
  a_page_next: assert property (s_nav ##0 btn_down_i |=> page_o == (($past(page_o) == PAGE_LAST) ? PAGE_FIRST : $past(page_o) + 5'h01))
    else $error("down press went to wrong page");
  a_page_prev: assert property (s_nav ##0 btn_up_i |=> page_o == (($past(page_o) == PAGE_FIRST) ? PAGE_LAST : $past(page_o) - 5'h01))
    else $error("up press went to wrong page");
  a_boot_first: assert property (!firmware_run_o |-> !display_on_o)
    else $error("display on before boot wait");
  a_boot_stays: assert property (firmware_run_o |=> firmware_run_o)
    else $error("firmware run dropped");
  a_led_mains: assert property (green_led_o == mains_present_i)
    else $error("green led does not follow mains");
  a_route_card: assert property (output_start_i && firmware_run_o |=> route_o == ($past(card_present_i) ? LDM_OUT_CARD : LDM_OUT_SERIAL))
    else $error("output routed wrongly");
endmodule

bind ldm_top ldm_top_chk u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .sec_tick_i(sec_tick_i), .btn_enter_i(btn_enter_i), .btn_up_i(btn_up_i),
  .btn_down_i(btn_down_i), .card_present_i(card_present_i),
  .mains_present_i(mains_present_i), .output_start_i(output_start_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .firmware_run_o(firmware_run_o), .display_on_o(display_on_o),
  .page_o(page_o), .line1_lead_o(line1_lead_o), .green_led_o(green_led_o),
  .route_o(route_o));

// file: testbench/ldm_operator.sv
/*
  Operator model: presses the three front-panel buttons.
  Assumes its tasks are called at a rising edge of clk_i.
*/
`timescale 1ns/100ps
module ldm_operator (
  input  wire logic clk_i,
  output logic      btn_enter_o,
  output logic      btn_up_o,
  output logic      btn_down_o
);
  initial begin
    btn_enter_o = 1'b0;
    btn_up_o = 1'b0;
    btn_down_o = 1'b0;
  end

  // Select is held well short of the half-second limit.
  task automatic press_enter(input int cycles);
    btn_enter_o <= 1'b1;
    repeat (cycles) @(posedge clk_i);
    btn_enter_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic press(input logic down);
    btn_down_o <= down;
    btn_up_o <= !down;
    @(posedge clk_i);
    btn_down_o <= 1'b0;
    btn_up_o <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask
endmodule

// file: testbench/ldm_top_test.sv
/*
  Testbench for ldm_top: boot, wake, navigation, registers and idle-off.
  Assumes shortened counts: 2 s boot, 3 s idle, 40-cycle second tick.
*/
`timescale 1ns/100ps
module ldm_top_test;
  import ldm_pkg::*;
  localparam int TICK = 40;
  logic        clk_i = 1'b0, rst_i = 1'b1, sec_tick_i = 1'b0;
  logic        btn_enter_i, btn_up_i, btn_down_i;
  logic        serial_activity_i = 1'b0, card_present_i = 1'b0;
  logic        mains_present_i = 1'b0, param_mem_ok_i = 1'b1;
  logic        output_start_i = 1'b0;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [13:0] battery_dv_i = 14'h0080;
  logic [3:0]  sensor_present_i = 4'h7, sensor_testable_i = 4'hD;
  logic [3:0]  sensor_range_ok_i = 4'hE;
  logic [13:0] rain1_count_i = 14'h0000, rain2_count_i = 14'h0000;
  logic [15:0] temp_i = 16'h0123, humid_i = 16'h0456;
  logic [31:0] card_identity_record_i = 32'h1234_5678;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd_q;
  logic        wb_ack_o, firmware_run_o, display_on_o, green_led_o;
  logic [4:0]  page_o;
  logic [7:0]  line1_lead_o, line2_lead_o, c0;
  logic [1:0]  route_o;
  logic [5:0]  tick_cnt = 6'd0;
  int          miscompares = 0, n_checks = 0, cyc_n = 0, t0;

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    tick_cnt <= (tick_cnt == 6'd39) ? 6'd0 : tick_cnt + 6'd1;
    sec_tick_i <= (tick_cnt == 6'd39);
  end

  ldm_operator op (.clk_i(clk_i), .btn_enter_o(btn_enter_i),
    .btn_up_o(btn_up_i), .btn_down_o(btn_down_i));

  ldm_top #(.BOOT_SECONDS(2), .IDLE_SECONDS(3), .PRESS_CYCLES(8)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .sec_tick_i(sec_tick_i),
    .btn_enter_i(btn_enter_i), .btn_up_i(btn_up_i), .btn_down_i(btn_down_i),
    .serial_activity_i(serial_activity_i), .card_present_i(card_present_i),
    .mains_present_i(mains_present_i), .param_mem_ok_i(param_mem_ok_i),
    .battery_dv_i(battery_dv_i), .sensor_present_i(sensor_present_i),
    .sensor_testable_i(sensor_testable_i),
    .sensor_range_ok_i(sensor_range_ok_i), .rain1_count_i(rain1_count_i),
    .rain2_count_i(rain2_count_i), .temp_i(temp_i), .humid_i(humid_i),
    .card_identity_record_i(card_identity_record_i),
    .output_start_i(output_start_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .firmware_run_o(firmware_run_o), .display_on_o(display_on_o),
    .page_o(page_o), .line1_lead_o(line1_lead_o),
    .line2_lead_o(line2_lead_o), .green_led_o(green_led_o),
    .route_o(route_o));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic timeout();
    $display("ERROR at %0t: wait ran out", $time);
    miscompares++;
    final_report();
  endtask

  // One classic Wishbone cycle; read data lands in rd_q.
  task automatic wb(input logic we, input logic [7:0] adr,
                    input logic [31:0] dat);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do begin
      @(posedge clk_i);
      n++;
      if (n > 20) timeout();
    end while (wb_ack_o !== 1'b1);
    rd_q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_for(input logic on, input logic v);
    int n;
    n = 0;
    while ((on ? display_on_o : firmware_run_o) !== v) begin
      @(posedge clk_i);
      n++;
      if (n > 400) timeout();
    end
  endtask

  logic [31:0] ser [5] = '{32'h0000_000A, 32'h000B_1619, 32'h000B_1719,
                           32'h000C_1619, 32'h000B_1609};
  logic [31:0] msk [5] = '{32'h0000_000F, 32'h000F_1F1F, 32'h0000_1F00,
                           32'h000F_0000, 32'h0000_001F};
  logic [31:0] exs [5] = '{32'h0000_0005, 32'h000B_1619, 32'h0000_1600,
                           32'h000B_0000, 32'h0000_0009};
  logic [13:0] bat [4] = '{14'h0074, 14'h0073, 14'h006A, 14'h0069};

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t0 = cyc_n;
    check({display_on_o, page_o, route_o}, 32'h0);
    op.press_enter(4);
    repeat (20) @(posedge clk_i);
    check({firmware_run_o, display_on_o}, 32'h0);
    wait_for(1'b0, 1'b1);
    check(32'(cyc_n - t0 <= 3 * TICK + 4), 32'h1);
    $display("test boot done");
    op.press_enter(4);
    wait_for(1'b1, 1'b1);
    check(page_o, PAGE_STATION);
    for (int i = 0; i < 20; i++) begin
      op.press(1'b1);
      check(page_o, (i + 1) % 20);
      check(line1_lead_o, PAGE_EDIT_MASK[page_o] ? CH_ASTERISK : CH_SPACE);
    end
    op.press(1'b0);
    check(page_o, PAGE_LAST);
    repeat (4) op.press(1'b1);
    wb(1'b1, 8'h00, 32'h0000_0047);
    check(line2_lead_o, CH_M);
    repeat (3) op.press(1'b0);
    check(line2_lead_o, CH_SPACE);
    $display("test navigation done");
    for (int i = 0; i < 5; i++) begin
      wb(1'b1, 8'h0C, ser[i]);
      wb(1'b0, 8'h0C, 32'h0);
      check(rd_q & msk[i], exs[i]);
    end
    for (int i = 0; i < 4; i++) begin
      battery_dv_i <= bat[i];
      mains_present_i <= i[0];
      param_mem_ok_i <= i[1];
      repeat (TICK + 2) @(posedge clk_i);
      wb(1'b0, 8'h10, 32'h0);
      check(rd_q[19:18], (i == 0) ? 0 : (i == 3) ? 2 : 1);
      check({rd_q[31], rd_q[17:16]}, {1'b1, i[1], i[0]});
      check(rd_q[7:0], 8'h81);
    end
    wb(1'b0, 8'h1C, 32'h0);
    c0 = rd_q[7:0];
    check(rd_q[31:8], {CH_X, CH_PLUS, CH_QUEST});
    wb(1'b1, 8'h00, 32'h0000_0017);
    rain1_count_i <= 14'h2710;
    rain2_count_i <= 14'h0123;
    temp_i <= 16'h0321;
    humid_i <= 16'h0654;
    repeat (TICK + 2) @(posedge clk_i);
    wb(1'b0, 8'h14, 32'h0);
    check(rd_q, {2'h0, 14'h0123, 2'h0, RAIN_MAX});
    wb(1'b0, 8'h1C, 32'h0);
    check(rd_q[7:0], (c0 === CH_PLUS) ? CH_ZERO : CH_PLUS);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, 8'h40, 32'h0);
    check(rd_q, 32'h0);
    wb(1'b0, 8'h18, 32'h0);
    check(rd_q, 32'h0654_0321);
    card_present_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    wb(1'b0, 8'h1C, 32'h0);
    check(rd_q, 32'h1234_5678);
    for (int i = 0; i < 2; i++) begin
      card_present_i <= i[0];
      output_start_i <= 1'b1;
      @(posedge clk_i);
      output_start_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      check(route_o, i[0] ? LDM_OUT_CARD : LDM_OUT_SERIAL);
    end
    $display("test registers done");
    wb(1'b1, 8'h00, 32'h0000_0047);
    op.press_enter(4);
    wait_for(1'b1, 1'b1);
    serial_activity_i <= 1'b1;
    @(posedge clk_i);
    serial_activity_i <= 1'b0;
    t0 = cyc_n;
    wait_for(1'b1, 1'b0);
    check(32'(cyc_n - t0 > 2 * TICK && cyc_n - t0 <= 4 * TICK + 4), 32'h1);
    wb(1'b0, 8'h00, 32'h0);
    check(rd_q[6], 1'b0);
    wb(1'b1, 8'h00, 32'h0000_0107);
    op.press_enter(4);
    wait_for(1'b1, 1'b1);
    repeat (5 * TICK) @(posedge clk_i);
    check(display_on_o, 1'b1);
    $display("test idle done");
    final_report();
  end
endmodule
